/* File: rtl/fault_alarm_pkg.sv */
// Package: register map, field positions, reset values and timing for the fault alarm logic
`default_nettype none
package fault_alarm_pkg;
   // Register byte addresses (printed offsets are not all multiples of four: index times four)
   localparam logic [7:0] IDX_PROTECT_ACTION = 8'h14;
   localparam logic [7:0] IDX_PIN_MASK_1 = 8'h16;
   localparam logic [7:0] IDX_CS_CFG_1 = 8'h18;
   localparam logic [7:0] IDX_CS_CFG_2 = 8'h1A;
   localparam logic [7:0] IDX_FILTER_TIME = 8'h1E;
   localparam logic [7:0] IDX_STATUS_1 = 8'h20;
   localparam logic [7:0] IDX_STATUS_2 = 8'h21;
   localparam logic [7:0] IDX_RAW_VIEW = 8'h22;
   localparam logic [7:0] IDX_CONTROL = 8'h23;
   localparam logic [9:0] ADDR_PROTECT_ACTION = {IDX_PROTECT_ACTION, 2'b00};
   localparam logic [9:0] ADDR_PIN_MASK_1 = {IDX_PIN_MASK_1, 2'b00};
   localparam logic [9:0] ADDR_CS_CFG_1 = {IDX_CS_CFG_1, 2'b00};
   localparam logic [9:0] ADDR_CS_CFG_2 = {IDX_CS_CFG_2, 2'b00};
   localparam logic [9:0] ADDR_FILTER_TIME = {IDX_FILTER_TIME, 2'b00};
   localparam logic [9:0] ADDR_STATUS_1 = {IDX_STATUS_1, 2'b00};
   localparam logic [9:0] ADDR_STATUS_2 = {IDX_STATUS_2, 2'b00};
   localparam logic [9:0] ADDR_RAW_VIEW = {IDX_RAW_VIEW, 2'b00};
   localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
   // Reset values
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'hFF;
   // Fault cause bit positions (common to mask, status and raw view)
   localparam int FB_THERMAL = 0;
   localparam int FB_OVERCURRENT = 1;
   localparam int FB_LOW_PUMP_UV = 2;
   localparam int FB_LOW_PUMP_OV = 3;
   localparam int FB_HIGH_PUMP_UV = 4;
   localparam int FB_HIGH_PUMP_OV1 = 5;
   localparam int FB_HIGH_PUMP_OV2 = 6;
   localparam int FB_REG5V_OV = 7;
   // Protect action enable register fields
   localparam int PA_THERMAL_DIS = 0;
   localparam int PA_OVERCURRENT_DIS = 1;
   localparam int PA_LOW_PUMP_UV_DIS = 2;
   localparam int PA_HIGH_PUMP_UV_DIS = 4;
   localparam logic [7:0] PA_WRITE_MASK = 8'h16;
   // Filter time register fields
   localparam int FT_OC_LSB = 0;
   localparam int FT_UV_LSB = 2;
   localparam int FT_REG5V = 4;
   localparam logic [7:0] FT_WRITE_MASK = 8'h1F;
   // Control register fields
   localparam int CT_LATCH_CLEAR = 0;
   localparam int CT_ACTION_SEL = 1;
   localparam int CT_MOTOR_EN = 2;
   localparam int CT_GLOBAL_ON = 3;
   localparam int CT_PUMP_REG_ON = 4;
   localparam int CT_PUMP_ON = 5;
   localparam int CT_SENSE_AMP_ON = 6;
   localparam logic [7:0] CT_WRITE_MASK = 8'h7E;
   // Filter step time per code unit and its cycle count at 50 MHz
   localparam int CLK_MHZ = 50;
   localparam int FILTER_STEP_NS = 1000;
   localparam int FILTER_STEP_CYC = FILTER_STEP_NS * CLK_MHZ / 1000;
   localparam int FILT_W = 8;
   // AHB transfer encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD = 3'b010;
endpackage
`default_nettype wire

/* File: rtl/fault_filter.sv */
// Module: qualifies a raw fault by requiring it to persist for a programmed wait time
`default_nettype none
module fault_filter
   import fault_alarm_pkg::*;
#(
   parameter int CODE_W = 2
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic raw_in,
   input wire logic [CODE_W-1:0] code_in,
   output logic qual_out
);
   logic [FILT_W-1:0] cnt_q;
   logic [FILT_W-1:0] limit;

   // Required persistence in cycles; code zero passes the fault at once
   assign limit = FILT_W'(int'(code_in) * FILTER_STEP_CYC);

   // Count cycles of a continuous raw fault, drop on any gap
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
         qual_out <= 1'b0;
      end else if (!raw_in) begin
         cnt_q <= '0;
         qual_out <= 1'b0;
      end else if (cnt_q >= limit) begin
         qual_out <= 1'b1;
      end else begin
         cnt_q <= cnt_q + FILT_W'(1);
      end
   end
endmodule
`default_nettype wire

/* File: rtl/motor_fault_alarm.sv */
// Module: motor pre-driver fault protection, alarm pin and status registers on AHB-Lite
//
// How it works
// - Overcurrent protect disable bit: 0 allows the protective action, 1 suppresses it.
// - Qualified overcurrent with protection allowed applies the action picked by action select.
// - Latched protection holds until host writes 1 to the fault latch clear bit.
// - Pump undervolt protection, and overcurrent protection with action select 0, stay latched after the cause clears.
// - Overcurrent detection runs only while the sense amplifier is powered on.
// - Thermal protection is always on; its disable bit reads 0 and ignores writes.
// - During thermal shutdown all motor drive outputs are forced low.
// - Thermal shutdown turns off the 5 V regulator enable, restored when it clears.
// - Pin mask bit 0 lets a cause reach the alarm pin; resets to all enabled.
// - Alarm pin returns high on a status 1 read after faults are gone, or once the cause's pin mask bit is set.
// - Pump voltage detections work only with global, pump regulator, pump and motor enabled.
// - Regulator overvolt and overcurrent each use their own filter field; both pump undervolts share one.
// - Overcurrent threshold comes from the sense settings; filtered by its wait field.
// - Thermal events before the system clock runs are never recorded as a cause.
// - Second status bits read 1 when clear and fall to 0 on detection.
// - Each status 1 detection except thermal is enabled only once its analog block is powered on.
// - Detected status holds until read; the read refreshes to present conditions.
`default_nettype none
module motor_fault_alarm
   import fault_alarm_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic ARST_N_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   input wire logic [7:0] FAULT_RAW_IN,
   input wire logic SECOND_FAULT_RAW_IN,
   input wire logic [5:0] DRIVE_REQ_IN,
   output logic [5:0] DRIVE_OUT,
   output logic REG5V_ENABLE_OUT,
   output logic ALARM_N_OUT,
   output logic [7:0] CURRENT_SENSE_CFG_1_OUT,
   output logic [7:0] CURRENT_SENSE_CFG_2_OUT
);
   logic rst_sync1_q;
   logic rst_n;
   logic [7:0] protect_action_enable_reg_q;
   logic [7:0] alarm_pin_mask_1_q;
   logic [7:0] filter_time_q;
   logic [7:0] control_q;
   logic [7:0] fault_status_1_q;
   logic fault_status_2_q;
   logic clock_seen_q;
   logic oc_latch_q;
   logic uv_latch_q;
   logic stop_q;
   logic wr_pend_q;
   logic rd_pend_q;
   logic [9:0] addr_q;
   logic [7:0] det;
   logic [7:0] filt;
   logic pump_ok;
   logic sense_ok;
   logic overcurrent_fault;
   logic thermal_shutdown_fault;
   logic acc;
   logic rd1;
   logic rd2;
   logic wr_ctl;
   logic clr_pulse;

   // Reset release through two flip-flops
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rst_sync1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_sync1_q <= 1'b1;
         rst_n <= rst_sync1_q;
      end
   end

   // Analog block power gating of each detection except thermal
   assign pump_ok = control_q[CT_GLOBAL_ON] & control_q[CT_PUMP_REG_ON] & control_q[CT_PUMP_ON]
      & control_q[CT_MOTOR_EN];
   assign sense_ok = control_q[CT_GLOBAL_ON] & control_q[CT_SENSE_AMP_ON];
   always_comb begin
      det = FAULT_RAW_IN;
      det[FB_OVERCURRENT] = FAULT_RAW_IN[FB_OVERCURRENT] & sense_ok;
      det[FB_LOW_PUMP_UV] = FAULT_RAW_IN[FB_LOW_PUMP_UV] & pump_ok;
      det[FB_LOW_PUMP_OV] = FAULT_RAW_IN[FB_LOW_PUMP_OV] & pump_ok;
      det[FB_HIGH_PUMP_UV] = FAULT_RAW_IN[FB_HIGH_PUMP_UV] & pump_ok;
      det[FB_HIGH_PUMP_OV1] = FAULT_RAW_IN[FB_HIGH_PUMP_OV1] & pump_ok;
      det[FB_HIGH_PUMP_OV2] = FAULT_RAW_IN[FB_HIGH_PUMP_OV2] & pump_ok;
      det[FB_REG5V_OV] = FAULT_RAW_IN[FB_REG5V_OV] & control_q[CT_GLOBAL_ON];
   end

   // Filtered causes; both pump undervolt filters share one wait field
   fault_filter #(.CODE_W(2)) oc_filter (
      .clk_in(CLK_IN), .rst_n_in(rst_n), .raw_in(det[FB_OVERCURRENT]),
      .code_in(filter_time_q[FT_OC_LSB +: 2]), .qual_out(filt[FB_OVERCURRENT])
   );
   fault_filter #(.CODE_W(2)) lo_uv_filter (
      .clk_in(CLK_IN), .rst_n_in(rst_n), .raw_in(det[FB_LOW_PUMP_UV]),
      .code_in(filter_time_q[FT_UV_LSB +: 2]), .qual_out(filt[FB_LOW_PUMP_UV])
   );
   fault_filter #(.CODE_W(2)) hi_uv_filter (
      .clk_in(CLK_IN), .rst_n_in(rst_n), .raw_in(det[FB_HIGH_PUMP_UV]),
      .code_in(filter_time_q[FT_UV_LSB +: 2]), .qual_out(filt[FB_HIGH_PUMP_UV])
   );
   fault_filter #(.CODE_W(1)) reg_ov_filter (
      .clk_in(CLK_IN), .rst_n_in(rst_n), .raw_in(det[FB_REG5V_OV]),
      .code_in(filter_time_q[FT_REG5V +: 1]), .qual_out(filt[FB_REG5V_OV])
   );
   assign filt[FB_THERMAL] = det[FB_THERMAL];
   assign filt[FB_LOW_PUMP_OV] = det[FB_LOW_PUMP_OV];
   assign filt[FB_HIGH_PUMP_OV1] = det[FB_HIGH_PUMP_OV1];
   assign filt[FB_HIGH_PUMP_OV2] = det[FB_HIGH_PUMP_OV2];
   assign overcurrent_fault = filt[FB_OVERCURRENT];
   assign thermal_shutdown_fault = FAULT_RAW_IN[FB_THERMAL];

   // Bus decode of the address phase
   assign acc = HSEL_IN & HREADY_IN & (HTRANS_IN == HTRANS_NONSEQ);
   assign rd1 = rd_pend_q & (addr_q == ADDR_STATUS_1);
   assign rd2 = rd_pend_q & (addr_q == ADDR_STATUS_2);
   assign wr_ctl = wr_pend_q & (addr_q == ADDR_CONTROL);
   assign clr_pulse = wr_ctl & HWDATA_IN[CT_LATCH_CLEAR];

   // Address phase capture; slave answers with no wait states
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= '0;
      end else begin
         wr_pend_q <= acc & HWRITE_IN;
         rd_pend_q <= acc & ~HWRITE_IN;
         addr_q <= (HSIZE_IN == HSIZE_WORD) ? HADDR_IN[9:0] : 10'h3FF;
      end
   end

   // Software writable registers
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         protect_action_enable_reg_q <= RST_REG8;
         alarm_pin_mask_1_q <= RST_REG8;
         filter_time_q <= RST_REG8;
         control_q <= RST_REG8;
         CURRENT_SENSE_CFG_1_OUT <= RST_REG8;
         CURRENT_SENSE_CFG_2_OUT <= RST_REG8;
      end else if (wr_pend_q) begin
         unique case (addr_q)
            ADDR_PROTECT_ACTION: protect_action_enable_reg_q <= HWDATA_IN[7:0] & PA_WRITE_MASK;
            ADDR_PIN_MASK_1: alarm_pin_mask_1_q <= HWDATA_IN[7:0];
            ADDR_FILTER_TIME: begin
               if (!control_q[CT_MOTOR_EN]) begin
                  filter_time_q <= HWDATA_IN[7:0] & FT_WRITE_MASK;
               end
            end
            ADDR_CONTROL: control_q <= HWDATA_IN[7:0] & CT_WRITE_MASK;
            ADDR_CS_CFG_1: CURRENT_SENSE_CFG_1_OUT <= HWDATA_IN[7:0];
            ADDR_CS_CFG_2: CURRENT_SENSE_CFG_2_OUT <= HWDATA_IN[7:0];
            default: ;
         endcase
      end
   end

   // Clock-running marker: thermal events before it are not recorded
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         clock_seen_q <= 1'b0;
      end else begin
         clock_seen_q <= 1'b1;
      end
   end

   // Status 1: active low, holds detections until read, then refreshes; set wins over read
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         fault_status_1_q <= RST_STATUS;
      end else if (rd1) begin
         fault_status_1_q <= ~filt | {7'h00, ~clock_seen_q};
      end else begin
         fault_status_1_q <= fault_status_1_q & ~(filt & {7'h7F, clock_seen_q});
      end
   end

   // Status 2: single undervolt cause, same hold-until-read behaviour
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         fault_status_2_q <= 1'b1;
      end else if (rd2) begin
         fault_status_2_q <= ~SECOND_FAULT_RAW_IN;
      end else if (SECOND_FAULT_RAW_IN) begin
         fault_status_2_q <= 1'b0;
      end
   end

   // Latched protection for overcurrent and pump undervolts; fault wins over clear
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         oc_latch_q <= 1'b0;
         uv_latch_q <= 1'b0;
      end else begin
         if (overcurrent_fault & ~protect_action_enable_reg_q[PA_OVERCURRENT_DIS]) begin
            oc_latch_q <= 1'b1;
         end else if (clr_pulse) begin
            oc_latch_q <= 1'b0;
         end
         if ((filt[FB_LOW_PUMP_UV] & ~protect_action_enable_reg_q[PA_LOW_PUMP_UV_DIS])
               | (filt[FB_HIGH_PUMP_UV] & ~protect_action_enable_reg_q[PA_HIGH_PUMP_UV_DIS])) begin
            uv_latch_q <= 1'b1;
         end else if (clr_pulse) begin
            uv_latch_q <= 1'b0;
         end
      end
   end

   // Drive stop: action select 0 stops all, 1 stops only while fault persists
   always_comb begin
      stop_q = uv_latch_q;
      if (oc_latch_q) begin
         stop_q = control_q[CT_ACTION_SEL] ? (uv_latch_q | overcurrent_fault) : 1'b1;
      end
   end

   // Motor drive outputs and 5 V regulator enable
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         DRIVE_OUT <= '0;
         REG5V_ENABLE_OUT <= 1'b0;
      end else begin
         if (thermal_shutdown_fault | stop_q | ~control_q[CT_MOTOR_EN]) begin
            DRIVE_OUT <= '0;
         end else begin
            DRIVE_OUT <= DRIVE_REQ_IN;
         end
         REG5V_ENABLE_OUT <= ~thermal_shutdown_fault;
      end
   end

   // Alarm pin: low on unmasked status, high again after the status 1 read refresh
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         ALARM_N_OUT <= 1'b1;
      end else begin
         ALARM_N_OUT <= ~|(~fault_status_1_q & ~alarm_pin_mask_1_q);
      end
   end

   // Read data and response
   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         HRDATA_OUT <= '0;
         HREADYOUT_OUT <= 1'b1;
         HRESP_OUT <= 1'b0;
      end else begin
         HREADYOUT_OUT <= 1'b1;
         HRESP_OUT <= 1'b0;
         HRDATA_OUT <= '0;
         if (acc & ~HWRITE_IN) begin
            unique case (HADDR_IN[9:0])
               ADDR_PROTECT_ACTION: HRDATA_OUT <= {24'h000000, protect_action_enable_reg_q};
               ADDR_PIN_MASK_1: HRDATA_OUT <= {24'h000000, alarm_pin_mask_1_q};
               ADDR_CS_CFG_1: HRDATA_OUT <= {24'h000000, CURRENT_SENSE_CFG_1_OUT};
               ADDR_CS_CFG_2: HRDATA_OUT <= {24'h000000, CURRENT_SENSE_CFG_2_OUT};
               ADDR_FILTER_TIME: HRDATA_OUT <= {24'h000000, filter_time_q};
               ADDR_STATUS_1: HRDATA_OUT <= {24'h000000, fault_status_1_q};
               ADDR_STATUS_2: HRDATA_OUT <= {31'h00000000, fault_status_2_q};
               ADDR_RAW_VIEW: HRDATA_OUT <= {24'h000000, ~FAULT_RAW_IN};
               ADDR_CONTROL: HRDATA_OUT <= {24'h000000, control_q};
               default: HRDATA_OUT <= '0;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/motor_fault_alarm_monitor.sv */
// Checker of bus, alarm pin and protection relations at the top ports
`default_nettype none
module motor_fault_alarm_monitor
   import fault_alarm_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic ARST_N_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   input wire logic [31:0] HRDATA_OUT,
   input wire logic HREADYOUT_OUT,
   input wire logic HRESP_OUT,
   input wire logic [7:0] FAULT_RAW_IN,
   input wire logic SECOND_FAULT_RAW_IN,
   input wire logic [5:0] DRIVE_REQ_IN,
   input wire logic [5:0] DRIVE_OUT,
   input wire logic REG5V_ENABLE_OUT,
   input wire logic ALARM_N_OUT,
   input wire logic [7:0] CURRENT_SENSE_CFG_1_OUT,
   input wire logic [7:0] CURRENT_SENSE_CFG_2_OUT
);
   logic req;
   logic st_rd;
   logic flt;
   // Accepted transfer, status read and any raw fault
   assign req = HSEL_IN && HREADY_IN && HTRANS_IN == HTRANS_NONSEQ;
   assign st_rd = req && !HWRITE_IN && (HADDR_IN[9:0] == ADDR_STATUS_1 || HADDR_IN[9:0] == ADDR_STATUS_2);
   assign flt = (|FAULT_RAW_IN) || SECOND_FAULT_RAW_IN;
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!ARST_N_IN);
   a_resp_okay: assert property (HRESP_OUT == 1'b0) else $error("bus response not okay");
   a_ready_high: assert property (HREADYOUT_OUT == 1'b1) else $error("wait state inserted");
   a_data_stands: assert property (HRDATA_OUT != 32'h0 |-> $past(req)) else $error("read data outside data phase");
   a_thermal_bit0: assert property ($past(req && HADDR_IN[9:0] == ADDR_PROTECT_ACTION) |-> !HRDATA_OUT[0])
      else $error("thermal disable bit reads one");
   a_thermal_drive: assert property (FAULT_RAW_IN[FB_THERMAL] [*3] |-> DRIVE_OUT == 6'h00)
      else $error("drive not low in thermal shutdown");
   a_reg5v_off: assert property (FAULT_RAW_IN[FB_THERMAL] |=> !REG5V_ENABLE_OUT)
      else $error("regulator enabled in thermal shutdown");
   a_alarm_rise: assert property ($rose(ALARM_N_OUT) |-> $past(st_rd, 2) || $past(st_rd, 3))
      else $error("alarm released without status read");
   a_alarm_fall: assert property ($fell(ALARM_N_OUT) |-> $past(flt, 2) || $past(flt, 3) || $past(flt, 4))
      else $error("alarm raised without fault");
   a_status_hold: assert property (FAULT_RAW_IN[0] [*4] ##1 (st_rd && HADDR_IN[9:0] == ADDR_STATUS_1)
      |=> !HRDATA_OUT[FB_THERMAL]) else $error("thermal status not held");
   a_cfg_copy: assert property ($changed(CURRENT_SENSE_CFG_1_OUT) |-> $past(req && HWRITE_IN, 2))
      else $error("sense setting changed without write");
endmodule
bind motor_fault_alarm motor_fault_alarm_monitor mon (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .HSEL_IN(HSEL_IN),
   .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HSIZE_IN(HSIZE_IN), .HWDATA_IN(HWDATA_IN),
   .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
   .FAULT_RAW_IN(FAULT_RAW_IN), .SECOND_FAULT_RAW_IN(SECOND_FAULT_RAW_IN), .DRIVE_REQ_IN(DRIVE_REQ_IN),
   .DRIVE_OUT(DRIVE_OUT), .REG5V_ENABLE_OUT(REG5V_ENABLE_OUT), .ALARM_N_OUT(ALARM_N_OUT),
   .CURRENT_SENSE_CFG_1_OUT(CURRENT_SENSE_CFG_1_OUT), .CURRENT_SENSE_CFG_2_OUT(CURRENT_SENSE_CFG_2_OUT));
`default_nettype wire

/* File: tb/ahb_host_model.sv */
// Host side bus master making single word transfers
`default_nettype none
module ahb_host_model
   import fault_alarm_pkg::*;
(
   input wire logic clk_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_in,
   output logic hsel_out,
   output logic [31:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output logic [2:0] hsize_out,
   output logic [31:0] hwdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      hsel_out = 1'b0;
      haddr_out = 32'h0;
      htrans_out = 2'b00;
      hwrite_out = 1'b0;
      hsize_out = HSIZE_WORD;
      hwdata_out = 32'h0;
   end
   // One transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel_out <= 1'b1;
      htrans_out <= HTRANS_NONSEQ;
      haddr_out <= {22'h0, a};
      hwrite_out <= w;
      // Address phase holds until ready is seen high at a rising edge
      @(posedge clk_in);
      while (hready_in !== 1'b1) @(posedge clk_in);
      hsel_out <= 1'b0;
      htrans_out <= 2'b00;
      hwdata_out <= wd;
      // Data phase holds until ready again; read data taken at that edge
      @(posedge clk_in);
      while (hready_in !== 1'b1) @(posedge clk_in);
      rd = hrdata_in;
      hwdata_out <= ~wd; // Released data turns over
      #1; // Leave the edge so outputs are settled for the caller
   endtask
endmodule
`default_nettype wire

/* File: tb/tb_motor_fault_alarm.sv */
// Testbench for protection, alarm pin and status registers
`default_nettype none
module tb_motor_fault_alarm
   import fault_alarm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic hsel, hwrite, hready, hresp, second_raw = 1'b0, reg5v, alarm_n;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] fault_raw = 8'h00, cs1, cs2;
   logic [5:0] drive_req = 6'h00, drive;
   int n_mismatch = 0;
   int tests_run = 0;
   int cyc = 0;
   // Free running clock
   initial begin
      forever #10 clk = ~clk;
   end
   motor_fault_alarm DUT (.CLK_IN(clk), .ARST_N_IN(arst_n), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
      .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .FAULT_RAW_IN(fault_raw), .SECOND_FAULT_RAW_IN(second_raw),
      .DRIVE_REQ_IN(drive_req), .DRIVE_OUT(drive), .REG5V_ENABLE_OUT(reg5v), .ALARM_N_OUT(alarm_n),
      .CURRENT_SENSE_CFG_1_OUT(cs1), .CURRENT_SENSE_CFG_2_OUT(cs2));
   ahb_host_model host (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
      .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, {24'h0, d}, rdv);
   endtask
   task automatic rd_chk(input string what, input logic [9:0] a, input logic [7:0] e);
      host.xfer(1'b0, a, 32'h0, rdv);
      check(what, rdv, {24'h0, e});
   endtask
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1; // Outputs are looked at once settled
   endtask
   task automatic test_done();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Reset values, unmapped place and sense settings
   task automatic t_reset();
      check("alarm", 32'(alarm_n), 32'h1);
      rd_chk("mask1", ADDR_PIN_MASK_1, RST_REG8);
      rd_chk("status1", ADDR_STATUS_1, RST_STATUS);
      rd_chk("unmapped", 10'h3FC, 8'h00);
      wr(ADDR_CS_CFG_1, 8'hA5);
      wr(ADDR_CS_CFG_2, 8'h5A);
      rd_chk("cs1", ADDR_CS_CFG_1, 8'hA5);
      check("cs2 out", 32'(cs2), 32'h5A);
   endtask
   // Thermal shutdown, pin release on read and masking
   task automatic t_thermal();
      wr(ADDR_PROTECT_ACTION, 8'h01);
      rd_chk("action", ADDR_PROTECT_ACTION, 8'h00);
      wr(ADDR_CONTROL, 8'h7C);
      drive_req <= 6'h2D;
      fault_raw <= 8'h01;
      hold(6);
      check("drive", 32'(drive), 32'h0);
      check("reg5v", 32'(reg5v), 32'h0);
      check("alarm", 32'(alarm_n), 32'h0);
      fault_raw <= 8'h00;
      hold(4);
      check("reg5v", 32'(reg5v), 32'h1);
      check("alarm", 32'(alarm_n), 32'h0);
      rd_chk("status1", ADDR_STATUS_1, 8'hFE);
      hold(2);
      check("alarm", 32'(alarm_n), 32'h1);
      wr(ADDR_PIN_MASK_1, 8'h01);
      fault_raw <= 8'h01;
      hold(6);
      check("alarm", 32'(alarm_n), 32'h1);
      rd_chk("status1", ADDR_STATUS_1, 8'hFE);
      fault_raw <= 8'h00;
      hold(3);
      rd_chk("status1", ADDR_STATUS_1, 8'hFE);
      wr(ADDR_PIN_MASK_1, 8'h00);
   endtask
   // Overcurrent gating, filtering, latching and disable
   task automatic t_overcurrent();
      wr(ADDR_CONTROL, 8'h3C);
      fault_raw <= 8'h02;
      hold(10);
      fault_raw <= 8'h00;
      rd_chk("status1", ADDR_STATUS_1, 8'hFF);
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_FILTER_TIME, 8'h01);
      wr(ADDR_CONTROL, 8'h7C);
      for (int i = 0; i < 3; i++) begin
         if (i == 2) wr(ADDR_PROTECT_ACTION, 8'h02);
         fault_raw <= 8'h02;
         hold(i == 0 ? 45 : 55);
         fault_raw <= 8'h00;
         hold(3);
         check("drive", 32'(drive), i == 1 ? 32'h0 : 32'h2D);
         rd_chk("status1", ADDR_STATUS_1, i == 0 ? 8'hFF : 8'hFD);
         check("drive", 32'(drive), i == 1 ? 32'h0 : 32'h2D);
         wr(ADDR_CONTROL, 8'h7D);
         hold(3);
         check("drive", 32'(drive), 32'h2D);
      end
      wr(ADDR_PROTECT_ACTION, 8'h00);
   endtask
   // Pump undervolt with motor off, then latched with motor on
   task automatic t_pump();
      wr(ADDR_CONTROL, 8'h78);
      fault_raw <= 8'h04;
      hold(4);
      rd_chk("raw", ADDR_RAW_VIEW, 8'hFB);
      check("alarm", 32'(alarm_n), 32'h1);
      wr(ADDR_CONTROL, 8'h7C);
      hold(6);
      check("alarm", 32'(alarm_n), 32'h0);
      fault_raw <= 8'h00;
      second_raw <= 1'b1;
      hold(6);
      host.xfer(1'b0, ADDR_STATUS_2, 32'h0, rdv);
      check("status2", 32'(rdv[0]), 32'h0);
      rd_chk("status1", ADDR_STATUS_1, 8'hFB);
      check("drive", 32'(drive), 32'h0);
      second_raw <= 1'b0;
      wr(ADDR_CONTROL, 8'h7D);
      hold(3);
      check("drive", 32'(drive), 32'h2D);
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         test_done();
      end
   end
   // Main sequence
   initial begin
      hold(3);
      arst_n <= 1'b1;
      hold(3);
      t_reset();
      t_thermal();
      t_overcurrent();
      t_pump();
      test_done();
   end
endmodule
`default_nettype wire
